// [src/mfam_pkg.sv]
package mfam_pkg;

  // ***************************************
  // Data address window
  // ***************************************
  localparam logic [15:0] MFAM_WIN_FIRST    = 16'h6000;
  localparam logic [15:0] MFAM_WIN_LAST     = 16'h600f;
  localparam logic [15:0] MFAM_WR_LAST      = 16'h6007;

  // ***************************************
  // Function codes and exception codes
  // ***************************************
  localparam logic [7:0]  MFAM_FC_READ      = 8'h03;
  localparam logic [7:0]  MFAM_FC_WRITE     = 8'h10;
  localparam logic [7:0]  MFAM_FC_READWRITE = 8'h17;
  localparam logic [7:0]  MFAM_EXC_NONE     = 8'h00;
  localparam logic [7:0]  MFAM_EXC_FUNC     = 8'h01;
  localparam logic [7:0]  MFAM_EXC_ADDR     = 8'h02;
  localparam logic [7:0]  MFAM_EXC_QTY      = 8'h03;

  // ***************************************
  // Slot layout and item codes
  // ***************************************
  localparam int          MFAM_SLOTS        = 4;
  localparam logic [31:0] MFAM_SLOT_RESET   = 32'h0000_0000;
  localparam logic [31:0] MFAM_ITEM_FB_SPEED = 32'h0000_0002;
  localparam logic [1:0]  MFAM_WORD_HI      = 2'h0;
  localparam logic [1:0]  MFAM_WORD_LO      = 2'h1;

  // ***************************************
  // Sequencer states
  // ***************************************
  typedef enum logic [4:0] {
    MFAM_IDLE     = 5'b00001,
    MFAM_WRITE    = 5'b00010,
    MFAM_RD_ISSUE = 5'b00100,
    MFAM_RD_TAKE  = 5'b01000,
    MFAM_DONE     = 5'b10000
  } mfam_state_e;

endpackage

// [src/mfam_shadow_if.sv]
`timescale 1ns/100ps
// Write shadow port between sequencer and shadow memory
interface mfam_shadow_if;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [15:0] wr_data;
  logic [2:0]  rd_addr;
  logic [15:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem   (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [src/mfam_shadow_mem.sv]
`timescale 1ns/100ps
// Holds the words written by the current request, eight writable addresses
module mfam_shadow_mem
  import mfam_pkg::*;
(
  input  wire logic  clk_in,
  mfam_shadow_if.mem sh
);

  logic [15:0] mem_reg [8];
  logic [15:0] rd_data_reg;

  // ***************************************
  // Storage and registered read
  // ***************************************
  always_ff @(posedge clk_in) begin
    if (sh.wr_en) begin
      mem_reg[sh.wr_addr] <= sh.wr_data;
    end
    rd_data_reg <= mem_reg[sh.rd_addr];
  end

  assign sh.rd_data = rd_data_reg;

endmodule

// [src/mfam_top.sv]
// ***************************************
// ***************************************
`timescale 1ns/100ps
module mfam_top
  import mfam_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [31:0] free_slot_one_param_in,
  input  wire logic [31:0] free_slot_two_param_in,
  input  wire logic [31:0] free_slot_three_param_in,
  input  wire logic [31:0] free_slot_four_param_in,
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_fc_in,
  input  wire logic [15:0] req_rd_addr_in,
  input  wire logic [7:0]  req_rd_qty_in,
  input  wire logic [15:0] req_wr_addr_in,
  input  wire logic [7:0]  req_wr_qty_in,
  output logic             req_ready_out,
  input  wire logic        wr_word_valid_in,
  input  wire logic [15:0] wr_word_in,
  output logic             wr_word_ready_out,
  output logic             item_wr_valid_out,
  output logic [31:0]      item_wr_code_out,
  output logic [1:0]       item_wr_word_out,
  output logic [15:0]      item_wr_data_out,
  output logic [31:0]      rd_item_code_out,
  input  wire logic [31:0] item_data_in,
  output logic             rsp_word_valid_out,
  output logic [15:0]      rsp_word_out,
  output logic             rsp_done_out,
  output logic [7:0]       rsp_exc_out
);

  mfam_shadow_if sh ();

  mfam_shadow_mem u_shadow (
    .clk_in (clk_in),
    .sh     (sh)
  );

  // ***************************************
  // State
  // ***************************************
  mfam_state_e  state_reg, state_next;
  logic [31:0]  slot_reg [MFAM_SLOTS];
  logic [31:0]  slot_next [MFAM_SLOTS];
  logic         captured_reg, captured_next;
  logic [7:0]   fc_reg, fc_next;
  logic [15:0]  rd_addr_reg, rd_addr_next;
  logic [7:0]   rd_left_reg, rd_left_next;
  logic [15:0]  wr_addr_reg, wr_addr_next;
  logic [7:0]   wr_left_reg, wr_left_next;
  logic [7:0]   wmask_reg, wmask_next;
  logic [7:0]   exc_reg, exc_next;
  logic         req_ready_reg, req_ready_next;
  logic         wr_ready_reg, wr_ready_next;
  logic         iw_valid_reg, iw_valid_next;
  logic [31:0]  iw_code_reg, iw_code_next;
  logic [1:0]   iw_word_reg, iw_word_next;
  logic [15:0]  iw_data_reg, iw_data_next;
  logic [31:0]  rd_code_reg, rd_code_next;
  logic         rsp_valid_reg, rsp_valid_next;
  logic [15:0]  rsp_word_reg, rsp_word_next;
  logic         done_reg, done_next;
  logic [7:0]   exc_out_reg, exc_out_next;

  // Resolved item code for a slot; zero code means feedback speed
  function automatic logic [31:0] item_of(input logic [31:0] code);
    item_of = (code == MFAM_SLOT_RESET) ? MFAM_ITEM_FB_SPEED : code;
  endfunction

  // Whole span start..start+qty-1 lies inside first..last
  function automatic logic span_ok(input logic [15:0] start, input logic [7:0] qty,
                                   input logic [15:0] last);
    logic [16:0] end_addr;
    end_addr = {1'b0, start} + {9'h000, qty} - 17'h00001;
    span_ok  = (start >= MFAM_WIN_FIRST) && (end_addr <= {1'b0, last});
  endfunction

  logic rd_win_ok;
  logic wr_win_ok;

  // Windows per function code: reads the full area, writes slots one and two only
  assign rd_win_ok = span_ok(req_rd_addr_in, req_rd_qty_in, MFAM_WIN_LAST);
  assign wr_win_ok = span_ok(req_wr_addr_in, req_wr_qty_in, MFAM_WR_LAST);

  // ***************************************
  // Next-state logic
  // ***************************************
  always_comb begin
    state_next     = state_reg;
    captured_next  = 1'b1;
    for (int i = 0; i < MFAM_SLOTS; i++) begin
      slot_next[i] = slot_reg[i];
    end
    fc_next        = fc_reg;
    rd_addr_next   = rd_addr_reg;
    rd_left_next   = rd_left_reg;
    wr_addr_next   = wr_addr_reg;
    wr_left_next   = wr_left_reg;
    wmask_next     = wmask_reg;
    exc_next       = exc_reg;
    iw_valid_next  = 1'b0;
    iw_code_next   = iw_code_reg;
    iw_word_next   = iw_word_reg;
    iw_data_next   = iw_data_reg;
    rd_code_next   = rd_code_reg;
    rsp_valid_next = 1'b0;
    rsp_word_next  = rsp_word_reg;
    done_next      = 1'b0;
    exc_out_next   = exc_out_reg;
    sh.wr_en       = 1'b0;
    sh.wr_addr     = wr_addr_reg[2:0];
    sh.wr_data     = wr_word_in;
    sh.rd_addr     = rd_addr_reg[2:0];

    // Slot values are caught once after reset; later changes wait for the next reset
    if (!captured_reg) begin
      slot_next[0] = free_slot_one_param_in;
      slot_next[1] = free_slot_two_param_in;
      slot_next[2] = free_slot_three_param_in;
      slot_next[3] = free_slot_four_param_in;
    end

    unique case (state_reg)
      MFAM_IDLE: begin
        if (req_valid_in && req_ready_reg) begin
          fc_next      = req_fc_in;
          rd_addr_next = req_rd_addr_in;
          rd_left_next = req_rd_qty_in;
          wr_addr_next = req_wr_addr_in;
          wr_left_next = req_wr_qty_in;
          wmask_next   = 8'h00;
          exc_next     = MFAM_EXC_NONE;
          state_next   = MFAM_DONE;
          // Quantity is checked before the address window
          if (req_fc_in == MFAM_FC_READ) begin
            if (req_rd_qty_in == 8'h00) exc_next = MFAM_EXC_QTY;
            else if (!rd_win_ok) exc_next = MFAM_EXC_ADDR;
            else state_next = MFAM_RD_ISSUE;
          end else if (req_fc_in == MFAM_FC_WRITE) begin
            if (req_wr_qty_in == 8'h00) exc_next = MFAM_EXC_QTY;
            else if (!wr_win_ok) exc_next = MFAM_EXC_ADDR;
            else state_next = MFAM_WRITE;
          end else if (req_fc_in == MFAM_FC_READWRITE) begin
            if (req_rd_qty_in == 8'h00 || req_wr_qty_in == 8'h00) exc_next = MFAM_EXC_QTY;
            else if (!rd_win_ok || !wr_win_ok) exc_next = MFAM_EXC_ADDR;
            else state_next = MFAM_WRITE;
          end else begin
            exc_next = MFAM_EXC_FUNC;
          end
        end
      end
      MFAM_WRITE: begin
        if (wr_word_valid_in) begin
          // Word lands in the shadow so a read of the same address returns it
          sh.wr_en                     = 1'b1;
          wmask_next[wr_addr_reg[2:0]] = 1'b1;
          iw_valid_next = (wr_addr_reg[1:0] == MFAM_WORD_HI) || (wr_addr_reg[1:0] == MFAM_WORD_LO);
          iw_code_next  = item_of(slot_reg[wr_addr_reg[3:2]]);
          iw_word_next  = wr_addr_reg[1:0];
          iw_data_next  = wr_word_in;
          wr_addr_next  = wr_addr_reg + 16'h0001;
          wr_left_next  = wr_left_reg - 8'h01;
          if (wr_left_reg == 8'h01) begin
            state_next = (fc_reg == MFAM_FC_WRITE) ? MFAM_DONE : MFAM_RD_ISSUE;
          end
        end
      end
      MFAM_RD_ISSUE: begin
        rd_code_next = item_of(slot_reg[rd_addr_reg[3:2]]);
        state_next   = MFAM_RD_TAKE;
      end
      MFAM_RD_TAKE: begin
        rsp_valid_next = 1'b1;
        if (rd_addr_reg <= MFAM_WR_LAST && wmask_reg[rd_addr_reg[2:0]]) begin
          rsp_word_next = sh.rd_data;
        end else if (rd_addr_reg[1:0] == MFAM_WORD_HI) begin
          rsp_word_next = item_data_in[31:16];
        end else if (rd_addr_reg[1:0] == MFAM_WORD_LO) begin
          rsp_word_next = item_data_in[15:0];
        end else begin
          rsp_word_next = 16'h0000;
        end
        rd_addr_next = rd_addr_reg + 16'h0001;
        rd_left_next = rd_left_reg - 8'h01;
        state_next   = (rd_left_reg == 8'h01) ? MFAM_DONE : MFAM_RD_ISSUE;
      end
      MFAM_DONE: begin
        done_next    = 1'b1;
        exc_out_next = exc_reg;
        state_next   = MFAM_IDLE;
      end
      default: begin
        state_next = MFAM_IDLE;
      end
    endcase
  end

  // Handshake readies follow the coming state so they sit on flops
  assign req_ready_next = (state_next == MFAM_IDLE) && captured_next;
  assign wr_ready_next  = (state_next == MFAM_WRITE);

  // ***************************************
  // Registers
  // ***************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg     <= MFAM_IDLE;
      captured_reg  <= 1'b0;
      for (int i = 0; i < MFAM_SLOTS; i++) begin
        slot_reg[i] <= MFAM_SLOT_RESET;
      end
      fc_reg        <= 8'h00;
      rd_addr_reg   <= 16'h0000;
      rd_left_reg   <= 8'h00;
      wr_addr_reg   <= 16'h0000;
      wr_left_reg   <= 8'h00;
      wmask_reg     <= 8'h00;
      exc_reg       <= MFAM_EXC_NONE;
      req_ready_reg <= 1'b0;
      wr_ready_reg  <= 1'b0;
      iw_valid_reg  <= 1'b0;
      iw_code_reg   <= 32'h0000_0000;
      iw_word_reg   <= 2'h0;
      iw_data_reg   <= 16'h0000;
      rd_code_reg   <= 32'h0000_0000;
      rsp_valid_reg <= 1'b0;
      rsp_word_reg  <= 16'h0000;
      done_reg      <= 1'b0;
      exc_out_reg   <= MFAM_EXC_NONE;
    end else begin
      state_reg     <= state_next;
      captured_reg  <= captured_next;
      for (int i = 0; i < MFAM_SLOTS; i++) begin
        slot_reg[i] <= slot_next[i];
      end
      fc_reg        <= fc_next;
      rd_addr_reg   <= rd_addr_next;
      rd_left_reg   <= rd_left_next;
      wr_addr_reg   <= wr_addr_next;
      wr_left_reg   <= wr_left_next;
      wmask_reg     <= wmask_next;
      exc_reg       <= exc_next;
      req_ready_reg <= req_ready_next;
      wr_ready_reg  <= wr_ready_next;
      iw_valid_reg  <= iw_valid_next;
      iw_code_reg   <= iw_code_next;
      iw_word_reg   <= iw_word_next;
      iw_data_reg   <= iw_data_next;
      rd_code_reg   <= rd_code_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_word_reg  <= rsp_word_next;
      done_reg      <= done_next;
      exc_out_reg   <= exc_out_next;
    end
  end

  // ***************************************
  // Outputs, all from flops
  // ***************************************
  assign req_ready_out      = req_ready_reg;
  assign wr_word_ready_out  = wr_ready_reg;
  assign item_wr_valid_out  = iw_valid_reg;
  assign item_wr_code_out   = iw_code_reg;
  assign item_wr_word_out   = iw_word_reg;
  assign item_wr_data_out   = iw_data_reg;
  assign rd_item_code_out   = rd_code_reg;
  assign rsp_word_valid_out = rsp_valid_reg;
  assign rsp_word_out       = rsp_word_reg;
  assign rsp_done_out       = done_reg;
  assign rsp_exc_out        = exc_out_reg;

endmodule

// [dv/mfam_top_sva.sv]
`timescale 1ns/100ps
// ****
// Request and stream checks
// ****
module mfam_top_sva
  import mfam_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        req_valid_in,
  input wire logic [7:0]  req_fc_in,
  input wire logic [15:0] req_rd_addr_in,
  input wire logic [7:0]  req_rd_qty_in,
  input wire logic [15:0] req_wr_addr_in,
  input wire logic [7:0]  req_wr_qty_in,
  input wire logic        req_ready_out,
  input wire logic        wr_word_valid_in,
  input wire logic [15:0] wr_word_in,
  input wire logic        wr_word_ready_out,
  input wire logic        item_wr_valid_out,
  input wire logic [31:0] item_wr_code_out,
  input wire logic [15:0] item_wr_data_out,
  input wire logic        rsp_word_valid_out,
  input wire logic        rsp_done_out,
  input wire logic [7:0]  rsp_exc_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Spans in 17 bits so a list end never wraps
  logic        tk;
  logic        rd_bad;
  logic        wr_bad;
  logic [16:0] rd_end;
  logic [16:0] wr_end;
  assign tk = req_valid_in && req_ready_out;
  assign rd_end = {1'b0, req_rd_addr_in} + req_rd_qty_in - 17'h1;
  assign wr_end = {1'b0, req_wr_addr_in} + req_wr_qty_in - 17'h1;
  assign rd_bad = req_rd_addr_in < MFAM_WIN_FIRST || rd_end > {1'b0, MFAM_WIN_LAST};
  assign wr_bad = req_wr_addr_in < MFAM_WIN_FIRST || wr_end > {1'b0, MFAM_WR_LAST};
  // Exception answers come two cycles after the taking edge
  fc_reject_a: assert property (tk && !(req_fc_in inside {8'h03, 8'h10, 8'h17})
    |-> ##2 rsp_done_out && rsp_exc_out == MFAM_EXC_FUNC) else $error("unknown code not refused");
  qty_zero_a: assert property (tk && req_fc_in == 8'h17 && (req_rd_qty_in == 0 || req_wr_qty_in == 0)
    |-> ##2 rsp_done_out && rsp_exc_out == MFAM_EXC_QTY) else $error("empty list not refused");
  rd_span_a: assert property (tk && req_fc_in == 8'h03 && req_rd_qty_in != 0 && rd_bad
    |-> ##2 rsp_done_out && rsp_exc_out == MFAM_EXC_ADDR) else $error("read span not refused");
  wr_span_a: assert property (tk && req_fc_in == 8'h10 && req_wr_qty_in != 0 && wr_bad
    |-> ##2 rsp_done_out && rsp_exc_out == MFAM_EXC_ADDR) else $error("write span not refused");
  rw_span_a: assert property (tk && req_fc_in == 8'h17 && req_rd_qty_in != 0 && req_wr_qty_in != 0
    && (rd_bad || wr_bad) |-> ##2 rsp_done_out && rsp_exc_out == MFAM_EXC_ADDR) else $error("mixed span");
  rd_single_a: assert property (tk && req_fc_in == 8'h03 && req_rd_qty_in == 1 && !rd_bad
    |-> ##3 rsp_word_valid_out ##1 rsp_done_out && rsp_exc_out == MFAM_EXC_NONE) else $error("read timing");
  busy_hold_a: assert property (tk |=> !req_ready_out) else $error("ready while busy");
  wr_echo_a: assert property (item_wr_valid_out |-> $past(wr_word_valid_in && wr_word_ready_out)
    && item_wr_data_out == $past(wr_word_in)) else $error("item write without word");
  done_pulse_a: assert property (rsp_done_out |=> !rsp_done_out) else $error("done too long");
  code_zero_a: assert property (item_wr_valid_out |-> item_wr_code_out != 32'h0)
    else $error("zero item code");
  // Main scenarios reached
  c_read: cover property (tk && req_fc_in == 8'h03 ##[1:40] rsp_done_out);
  c_write: cover property (item_wr_valid_out);
  c_mixed: cover property (tk && req_fc_in == 8'h17 ##[1:40] rsp_word_valid_out);
endmodule

bind mfam_top mfam_top_sva u_sva (.*);

// [dv/mfam_item_model.sv]
`timescale 1ns/100ps
// ****
// Item store behind the core
// ****
module mfam_item_model (
  input  wire logic [31:0] code_in,
  output logic      [31:0] data_out
);
  // Same-cycle answer, so the sample one cycle later is always settled
  assign data_out = {~code_in[15:0], code_in[15:0] ^ 16'h5a5a};
endmodule

// [dv/test_modbus_free_address_map.sv]
`timescale 1ns/100ps
module test_modbus_free_address_map
  import mfam_pkg::*;
;
  // ****
  // Ports and bookkeeping
  // ****
  logic        clk_in, rst_n_in, req_valid_in, wr_word_valid_in, req_ready_out, wr_word_ready_out;
  logic [31:0] free_slot_one_param_in, free_slot_two_param_in, free_slot_three_param_in;
  logic [31:0] free_slot_four_param_in, item_wr_code_out, rd_item_code_out, item_data_in;
  logic [7:0]  req_fc_in, req_rd_qty_in, req_wr_qty_in, rsp_exc_out;
  logic [15:0] req_rd_addr_in, req_wr_addr_in, wr_word_in, item_wr_data_out, rsp_word_out;
  logic        item_wr_valid_out, rsp_word_valid_out, rsp_done_out;
  logic [1:0]  item_wr_word_out;
  logic [31:0] cap [4];
  int          err_count, cmp_count;

  mfam_top DUT (.*);
  mfam_item_model u_item (.code_in(rd_item_code_out), .data_out(item_data_in));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] item_val(input logic [31:0] c);
    return {~c[15:0], c[15:0] ^ 16'h5a5a};
  endfunction

  // Zero slot code stands for feedback speed
  function automatic logic [31:0] res(input int k);
    return (cap[k] == 32'h0) ? 32'h2 : cap[k];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Slots are taken only at the first edge after release
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cap = '{free_slot_one_param_in, free_slot_two_param_in, free_slot_three_param_in, free_slot_four_param_in};
    @(posedge clk_in);
  endtask

  // One request: stream writes, collect reads, judge the item-write, response word, done and exception outputs
  task automatic run(input logic [7:0] fc, input logic [15:0] ra, input logic [7:0] rq,
                     input logic [15:0] wa, input logic [7:0] wq, input logic [7:0] ex);
    logic [15:0] mem [16];
    logic [31:0] it, ec, ed;
    int          k, ew, nw, nr;
    bit          done, pend;
    {nw, nr, done, pend} = '0;
    for (k = 0; k < 16; k++) begin
      it = item_val(res(k / 4));
      mem[k] = (k % 4 == 0) ? it[31:16] : (k % 4 == 1) ? it[15:0] : 16'h0;
    end
    {req_fc_in, req_rd_addr_in, req_rd_qty_in, req_wr_addr_in, req_wr_qty_in} <= {fc, ra, rq, wa, wq};
    req_valid_in <= 1'b1;
    wr_word_valid_in <= (wq != 8'h0);
    wr_word_in <= 16'h9000 + wa;
    for (int t = 0; t < 100 && !done; t++) begin
      @(posedge clk_in);
      if (req_ready_out)
        req_valid_in <= 1'b0;
      if (pend || item_wr_valid_out) begin
        chk(item_wr_valid_out, pend);
        chk(item_wr_code_out, ec);
        chk(item_wr_data_out, ed);
        chk(item_wr_word_out, ew);
      end
      pend = 1'b0;
      if (wr_word_valid_in && wr_word_ready_out) begin
        k = wa + nw - 16'h6000;
        mem[k[3:0]] = wr_word_in;
        pend = (k % 4 < 2);
        ec = res(k / 4);
        ew = k % 4;
        ed = wr_word_in;
        nw++;
        if (nw == wq)
          wr_word_valid_in <= 1'b0;
        wr_word_in <= 16'h9000 + wa + nw[15:0];
      end
      if (rsp_word_valid_out) begin
        chk(rsp_word_out, mem[ra - 16'h6000 + nr]);
        nr++;
      end
      if (rsp_done_out) begin
        chk(rsp_exc_out, ex);
        done = 1'b1;
      end
    end
    if (!done) begin
      err_count++;
      close_out();
    end
    chk(nr, (ex == 8'h0 && fc != 8'h10) ? rq : 8'h0);
    chk(nw, (ex == 8'h0 && fc != 8'h03) ? wq : 8'h0);
    wr_word_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_read();
    run(8'h03, 16'h6000, 8'h10, 16'h0, 8'h0, 8'h00);
    run(8'h03, 16'h6004, 8'h01, 16'h0, 8'h0, 8'h00);
    run(8'h03, 16'h600f, 8'h02, 16'h0, 8'h0, 8'h02);
    run(8'h03, 16'h5fff, 8'h01, 16'h0, 8'h0, 8'h02);
  endtask

  task automatic t_write();
    run(8'h10, 16'h0, 8'h0, 16'h6000, 8'h08, 8'h00);
    run(8'h10, 16'h0, 8'h0, 16'h6006, 8'h03, 8'h02);
    run(8'h10, 16'h0, 8'h0, 16'h6008, 8'h01, 8'h02);
  endtask

  task automatic t_mixed();
    run(8'h17, 16'h6004, 8'h04, 16'h6004, 8'h02, 8'h00);
    run(8'h17, 16'h6006, 8'h0a, 16'h6000, 8'h08, 8'h00);
    run(8'h17, 16'h6000, 8'h01, 16'h6007, 8'h02, 8'h02);
    run(8'h17, 16'h600f, 8'h02, 16'h6000, 8'h01, 8'h02);
    run(8'h17, 16'h6000, 8'h00, 16'h6000, 8'h01, 8'h03);
    run(8'h17, 16'h6000, 8'h01, 16'h6000, 8'h00, 8'h03);
    run(8'h06, 16'h6000, 8'h01, 16'h6000, 8'h01, 8'h01);
  endtask

  // New slot codes wait for the next reset
  task automatic t_power();
    free_slot_one_param_in <= 32'h11;
    free_slot_four_param_in <= 32'h0;
    @(posedge clk_in);
    run(8'h03, 16'h6000, 8'h10, 16'h0, 8'h0, 8'h00);
    do_reset();
    run(8'h03, 16'h6000, 8'h10, 16'h0, 8'h0, 8'h00);
  endtask

  // Main sequence
  initial begin
    {req_valid_in, wr_word_valid_in, req_fc_in, req_rd_qty_in, req_wr_qty_in} = '0;
    {req_rd_addr_in, req_wr_addr_in, wr_word_in} = '0;
    rst_n_in = 1'b0;
    free_slot_one_param_in = 32'h0;
    free_slot_two_param_in = 32'h5;
    free_slot_three_param_in = 32'h7;
    free_slot_four_param_in = 32'h9;
    err_count = 0;
    cmp_count = 0;
    do_reset();
    t_read();
    t_write();
    t_mixed();
    t_power();
    close_out();
  end
endmodule
